// ### hdl/tksc_pkg.sv
/*
 Touch-key scan control: register map, field positions, reset values, sizes.
 Assumes a 32-bit APB register bus with one register per aligned word.
*/
package tksc_pkg;
	localparam int NMOD = 3;
	localparam int KEYS_PER_MOD = 4;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PRELOAD = 8'h04;
	localparam logic [7:0] ADDR_REF_COUNT = 8'h08;
	localparam logic [7:0] ADDR_IRQ = 8'h0c;
	localparam logic [7:0] ADDR_MOD_CTRL0 = 8'h10;
	localparam logic [7:0] ADDR_RESULT0 = 8'h20;
	localparam logic [7:0] ADDR_STRIDE = 8'h04;
	localparam int CTRL_SLOT_OVF = 6;
	localparam int CTRL_START = 5;
	localparam int CTRL_CYC_OVF = 4;
	localparam int CTRL_REF_OVF = 3;
	localparam int CTRL_SHARED = 2;
	localparam int CTRL_REF_SEL = 0;
	localparam int MC_SLOT_CLK = 7;
	localparam int MC_REF_EN = 5;
	localparam int MC_SENSE_EN = 4;
	localparam int MC_PIN_SEL = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] MOD_CTRL_RESET = 8'h00;
	localparam logic [7:0] PRELOAD_RESET = 8'h00;
	localparam logic [7:0] MOD_CTRL_MASK = 8'hbf;
	localparam logic [7:0] CTRL_MASK = 8'h7f;
	localparam logic [1:0] SLOT_DIV_SEL = 2'h2;
endpackage

// ### hdl/tksc_mod_if.sv
/*
 Signals between the scan controller and one touch-key measurement module.
 Assumes all signals are synchronous to pclk.
*/
`timescale 1ns/100ps
interface tksc_mod_if;
	logic clear;
	logic clear_timer;
	logic load;
	logic run;
	logic slot_tick;
	logic sense_tick;
	logic [7:0] preload;
	logic slot_ovf;
	logic done;
	logic [15:0] cycle_count;
	logic cycle_wrap;
	modport ctl (output clear, clear_timer, load, run, slot_tick, sense_tick, preload,
		input slot_ovf, done, cycle_count, cycle_wrap);
	modport mod (input clear, clear_timer, load, run, slot_tick, sense_tick, preload,
		output slot_ovf, done, cycle_count, cycle_wrap);
endinterface

// ### hdl/tksc_module.sv
/*
 One touch-key measurement module: 8+5-bit time-slot counter and cycle counter.
 Assumes slot and sense ticks are one-cycle pulses synchronous to pclk.
*/
`timescale 1ns/100ps
module tksc_module (
	input wire logic pclk,
	input wire logic presetn,
	tksc_mod_if.mod m
);
	import tksc_pkg::*;
	logic [7:0] timer_q;
	logic [4:0] slot_q;
	logic done_q;
	logic [15:0] cyc_q;
	logic tick_ok;
	logic timer_wrap;
	logic sense_ok;

	assign tick_ok = m.run & m.slot_tick & ~done_q;
	assign timer_wrap = tick_ok & (timer_q == 8'hff);
	// Wraps once per (256 - preload) x 32 slot ticks
	assign m.slot_ovf = timer_wrap & (slot_q == 5'h1f);
	assign sense_ok = m.run & ~done_q & m.sense_tick;
	assign m.cycle_wrap = sense_ok & (cyc_q == 16'hffff);
	assign m.done = done_q;
	assign m.cycle_count = cyc_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_q <= 8'h00;
		end else if (m.clear_timer) begin
			timer_q <= 8'h00;
		end else if (m.load) begin
			timer_q <= m.preload;
		end else if (timer_wrap) begin
			timer_q <= m.preload;
		end else if (tick_ok) begin
			timer_q <= timer_q + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_q <= 5'h00;
		end else if (m.clear || m.load) begin
			slot_q <= 5'h00;
		end else if (timer_wrap) begin
			slot_q <= slot_q + 5'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q <= 1'b0;
		end else if (m.clear || m.load) begin
			done_q <= 1'b0;
		end else if (m.slot_ovf) begin
			done_q <= 1'b1;
		end
	end

	// Result is sense cycles counted inside the slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc_q <= 16'h0000;
		end else if (m.clear || m.load) begin
			cyc_q <= 16'h0000;
		end else if (sense_ok) begin
			cyc_q <= cyc_q + 16'h0001;
		end
	end
endmodule // tksc_module

// ### hdl/tksc_top.sv
/*
 Touch-key scan controller: APB registers, start/stop sequencing, oscillator
 enables, pin function select, overflow flags and the scan interrupt request.
 Assumes oscillator ticks arrive as one-cycle pulses synchronous to pclk.
*/
`timescale 1ns/100ps
module tksc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [tksc_pkg::NMOD-1:0] ref_osc_tick,
	input wire logic [tksc_pkg::NMOD-1:0] sense_osc_tick,
	output logic [tksc_pkg::NMOD-1:0] ref_osc_enable,
	output logic [tksc_pkg::NMOD-1:0] sense_osc_enable,
	output logic [tksc_pkg::NMOD*tksc_pkg::KEYS_PER_MOD-1:0] pin_sense_select,
	output logic scan_interrupt_request
);
	import tksc_pkg::*;

	// Divider tick: low bits of prescaler all ones for the selected ratio
	function automatic logic div_tick(input logic [2:0] pre, input logic [1:0] sel);
		logic t;
		t = 1'b0;
		case (sel)
			2'h0: t = 1'b1;
			2'h1: t = pre[0];
			2'h2: t = &pre[1:0];
			2'h3: t = &pre;
			default: t = 1'b0;
		endcase
		return t;
	endfunction

	// Register address for module n at a base
	function automatic logic [7:0] mod_addr(input logic [7:0] base, input int n);
		return base + ADDR_STRIDE * n[7:0];
	endfunction

	logic [7:0] ctrl_q;
	logic [7:0] preload_q;
	logic [7:0] mod_ctrl_q [NMOD];
	logic [15:0] result_q [NMOD];
	logic [15:0] ref_cnt_q;
	logic [2:0] pre_q;
	logic irq_q;
	logic start_prev_q;
	logic running_q;
	logic stopped_q;
	logic [31:0] prdata_q;

	logic wr;
	logic setup;
	logic start_rise;
	logic gov_ovf;
	logic sys_div4;
	logic ref_tick;
	logic ref_wrap;
	logic any_cyc_wrap;
	logic addr_hit;
	logic [NMOD-1:0] mod_slot_ovf;
	logic [NMOD-1:0] mod_done;
	logic [NMOD-1:0] mod_keys_on;
	logic [NMOD-1:0] mod_cyc_wrap;
	logic [15:0] mod_cyc [NMOD];
	logic [31:0] rd_mux;

	tksc_mod_if mif [NMOD] ();

	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign start_rise = ctrl_q[CTRL_START] & ~start_prev_q;
	assign sys_div4 = div_tick(pre_q, SLOT_DIV_SEL);
	assign ref_tick = div_tick(pre_q, ctrl_q[CTRL_REF_SEL +: 2]);
	assign ref_wrap = running_q & ref_tick & (ref_cnt_q == 16'hffff);
	assign any_cyc_wrap = |mod_cyc_wrap;

	// Three identical modules, four keys each
	for (genvar n = 0; n < NMOD; n++) begin : g_mod
		tksc_module u_mod (
			.pclk(pclk),
			.presetn(presetn),
			.m(mif[n])
		);
		// Shared start/stop for all modules
		assign mif[n].run = running_q;
		assign mif[n].load = start_rise;
		assign mif[n].clear = ~ctrl_q[CTRL_START] | gov_ovf;
		assign mif[n].clear_timer = gov_ovf;
		assign mif[n].preload = preload_q;
		assign mif[n].sense_tick = sense_osc_tick[n] & mod_ctrl_q[n][MC_SENSE_EN];
		if (n == 0) begin : g_own
			assign mif[n].slot_tick = mod_ctrl_q[n][MC_SLOT_CLK] ? sys_div4
				: ref_osc_tick[n];
		end else begin : g_shr
			// In shared mode these modules are timed by module 0 instead
			assign mif[n].slot_tick = ~ctrl_q[CTRL_SHARED] &
				(mod_ctrl_q[n][MC_SLOT_CLK] ? sys_div4 : ref_osc_tick[n]);
		end
		assign mod_slot_ovf[n] = mif[n].slot_ovf;
		assign mod_done[n] = mif[n].done | mif[n].slot_ovf;
		assign mod_cyc_wrap[n] = mif[n].cycle_wrap;
		assign mod_cyc[n] = mif[n].cycle_count;
		assign mod_keys_on[n] = |mod_ctrl_q[n][MC_PIN_SEL +: KEYS_PER_MOD];
		// Oscillators run while enabled, halted after the slot ends
		assign ref_osc_enable[n] = mod_ctrl_q[n][MC_REF_EN] & ~stopped_q;
		assign sense_osc_enable[n] = mod_ctrl_q[n][MC_SENSE_EN] & ~stopped_q;
		assign pin_sense_select[n*KEYS_PER_MOD +: KEYS_PER_MOD] =
			mod_ctrl_q[n][MC_PIN_SEL +: KEYS_PER_MOD];
	end

	// Governing overflow: module 0 when shared, else all modules with keys on
	always_comb begin
		gov_ovf = 1'b0;
		if (running_q) begin
			if (ctrl_q[CTRL_SHARED]) begin
				gov_ovf = mod_slot_ovf[0];
			end else begin
				gov_ovf = (|mod_keys_on) & (|(mod_slot_ovf & mod_keys_on)) &
					(&(mod_done | ~mod_keys_on));
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 3'h0;
		end else begin
			pre_q <= pre_q + 3'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_prev_q <= 1'b0;
		end else begin
			start_prev_q <= ctrl_q[CTRL_START];
		end
	end

	// Measurement runs from the start edge until the governing overflow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			running_q <= 1'b0;
		end else if (!ctrl_q[CTRL_START] || gov_ovf) begin
			running_q <= 1'b0;
		end else if (start_rise) begin
			running_q <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stopped_q <= 1'b0;
		end else if (start_rise) begin
			stopped_q <= 1'b0;
		end else if (gov_ovf) begin
			stopped_q <= 1'b1;
		end
	end

	// Reference counter on the prescaled pclk tick; cleared with the others
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_cnt_q <= 16'h0000;
		end else if (!ctrl_q[CTRL_START] || gov_ovf || start_rise) begin
			ref_cnt_q <= 16'h0000;
		end else if (running_q && ref_tick) begin
			ref_cnt_q <= ref_cnt_q + 16'h0001;
		end
	end

	// Counters are wiped at overflow, so the counts are kept here for software
	for (genvar n = 0; n < NMOD; n++) begin : g_res
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				result_q[n] <= 16'h0000;
			end else if (gov_ovf) begin
				result_q[n] <= mod_cyc[n];
			end
		end
	end

	// Control register; hardware set of a flag wins over a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RESET;
		end else begin
			if (wr && paddr == ADDR_CTRL) begin
				ctrl_q <= pwdata[7:0] & CTRL_MASK;
			end
			if (gov_ovf) begin
				ctrl_q[CTRL_SLOT_OVF] <= 1'b1;
			end
			if (any_cyc_wrap) begin
				ctrl_q[CTRL_CYC_OVF] <= 1'b1;
			end
			if (ref_wrap) begin
				ctrl_q[CTRL_REF_OVF] <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			preload_q <= PRELOAD_RESET;
		end else if (wr && paddr == ADDR_PRELOAD) begin
			preload_q <= pwdata[7:0];
		end
	end

	for (genvar n = 0; n < NMOD; n++) begin : g_mc
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mod_ctrl_q[n] <= MOD_CTRL_RESET;
			end else if (wr && paddr == mod_addr(ADDR_MOD_CTRL0, n)) begin
				mod_ctrl_q[n] <= pwdata[7:0] & MOD_CTRL_MASK;
			end
		end
	end

	// Interrupt request flag, set wins over a software write of zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else if (gov_ovf) begin
			irq_q <= 1'b1;
		end else if (wr && paddr == ADDR_IRQ) begin
			irq_q <= pwdata[0];
		end
	end

	assign scan_interrupt_request = irq_q;

	// Read mux and decode
	always_comb begin
		rd_mux = 32'h0000_0000;
		addr_hit = 1'b0;
		case (paddr)
			ADDR_CTRL: begin
				rd_mux = {24'h000000, ctrl_q};
				addr_hit = 1'b1;
			end
			ADDR_PRELOAD: begin
				rd_mux = {24'h000000, preload_q};
				addr_hit = 1'b1;
			end
			ADDR_REF_COUNT: begin
				rd_mux = {16'h0000, ref_cnt_q};
				addr_hit = 1'b1;
			end
			ADDR_IRQ: begin
				rd_mux = {31'h00000000, irq_q};
				addr_hit = 1'b1;
			end
			default: begin
				for (int n = 0; n < NMOD; n++) begin
					if (paddr == mod_addr(ADDR_MOD_CTRL0, n)) begin
						rd_mux = {24'h000000, mod_ctrl_q[n]};
						addr_hit = 1'b1;
					end
					if (paddr == mod_addr(ADDR_RESULT0, n)) begin
						rd_mux = {16'h0000, result_q[n]};
						addr_hit = 1'b1;
					end
				end
			end
		endcase
	end

	// Read data captured in the setup cycle; no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_hit;
endmodule // tksc_top

// ### dv/tksc_osc_model.sv
/*
 Sense and reference oscillator model for three touch-key modules.
 Assumes pclk-synchronous enables; ticks are one-cycle pulses.
*/
`timescale 1ns/100ps
module tksc_osc_model
	import tksc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [tksc_pkg::NMOD-1:0] ref_en,
	input wire logic [tksc_pkg::NMOD-1:0] sense_en,
	output logic [tksc_pkg::NMOD-1:0] ref_tick,
	output logic [tksc_pkg::NMOD-1:0] sense_tick
);
	logic [2:0] cnt_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= cnt_q + 3'h1;
		end
	end
	// Stopped oscillator gives no ticks
	assign sense_tick = sense_en & {NMOD{cnt_q == 3'h0}};
	assign ref_tick = ref_en & {NMOD{cnt_q == 3'h4}};
endmodule // tksc_osc_model

// ### dv/tksc_checker.sv
/*
 Port-level assertions for the touch-key scan controller.
 Assumes it is bound to tksc_top and sees only its ports.
*/
`timescale 1ns/100ps
module tksc_checker
	import tksc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [tksc_pkg::NMOD-1:0] ref_osc_tick,
	input wire logic [tksc_pkg::NMOD-1:0] sense_osc_tick,
	input wire logic [tksc_pkg::NMOD-1:0] ref_osc_enable,
	input wire logic [tksc_pkg::NMOD-1:0] sense_osc_enable,
	input wire logic [tksc_pkg::NMOD*tksc_pkg::KEYS_PER_MOD-1:0] pin_sense_select,
	input wire logic scan_interrupt_request
);
	logic acc;
	logic wr;
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pin_select: assert property (wr && paddr == ADDR_MOD_CTRL0 |=>
		pin_sense_select[3:0] == $past(pwdata[3:0])) else $error("pin select mismatch");
	a_last_module_pins: assert property (wr && paddr == ADDR_MOD_CTRL0 + 8'h08 |=>
		pin_sense_select[11:8] == $past(pwdata[3:0])) else $error("module 2 pins mismatch");
	a_ref_osc_off: assert property (wr && paddr == ADDR_MOD_CTRL0 && !pwdata[5] |=>
		!ref_osc_enable[0]) else $error("reference osc still on");
	a_sense_osc_off: assert property (wr && paddr == ADDR_MOD_CTRL0 && !pwdata[4] |=>
		!sense_osc_enable[0]) else $error("sense osc still on");
	a_osc_stop: assert property ($rose(scan_interrupt_request) |->
		ref_osc_enable == '0 && sense_osc_enable == '0) else $error("osc not stopped");
	a_irq_sticky: assert property (scan_interrupt_request && !(wr && paddr == ADDR_IRQ) |=>
		scan_interrupt_request) else $error("irq dropped");
	a_unmapped_err: assert property (acc && paddr == 8'h40 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (acc && paddr == ADDR_CTRL |-> !pslverr && pready)
		else $error("mapped access refused");
	a_unused_bits: assert property (acc && !pwrite && paddr == ADDR_MOD_CTRL0 |->
		prdata[31:8] == 24'h0 && !prdata[6]) else $error("unused bits not zero");
endmodule // tksc_checker
bind tksc_top tksc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .ref_osc_tick(ref_osc_tick),
	.sense_osc_tick(sense_osc_tick), .ref_osc_enable(ref_osc_enable),
	.sense_osc_enable(sense_osc_enable), .pin_sense_select(pin_sense_select),
	.scan_interrupt_request(scan_interrupt_request));

// ### dv/tksc_top_tb.sv
/*
 Self-checking bench for the touch-key scan controller over APB.
 Assumes the oscillator model ticks sense every 8 pclk cycles.
*/
`timescale 1ns/100ps
module tksc_top_tb;
	import tksc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [NMOD-1:0] rtick, stick, ren, sen;
	logic [11:0] pins;
	int fail_count = 0;
	int checks = 0;
	int cyc;
	int exp_cyc;
	logic [7:0] raddr [8];
	tksc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ref_osc_tick(rtick), .sense_osc_tick(stick),
		.ref_osc_enable(ren), .sense_osc_enable(sen), .pin_sense_select(pins),
		.scan_interrupt_request(irq));
	tksc_osc_model u_osc (.pclk(pclk), .presetn(presetn), .ref_en(ren), .sense_en(sen),
		.ref_tick(rtick), .sense_tick(stick));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_rng(input int got, input int lo, input int hi, input string what);
		checks++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("MISMATCH %0t %s got %0d range %0d..%0d", $time, what, got, lo, hi);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ok;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		ok = (pready === 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (!ok) begin
			fail_count++;
			$display("MISMATCH %0t bus wait ran out", $time);
			stop_test();
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, "read");
	endtask
	task automatic wait_irq(input int lim);
		cyc = 0;
		while (irq !== 1'b1 && cyc < lim) begin
			@(posedge pclk);
			cyc++;
		end
		if (irq !== 1'b1) begin
			fail_count++;
			$display("MISMATCH %0t interrupt wait ran out", $time);
			stop_test();
		end
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		raddr = '{ADDR_CTRL, ADDR_PRELOAD, ADDR_REF_COUNT, ADDR_IRQ, ADDR_MOD_CTRL0,
			ADDR_MOD_CTRL0 + 8'h04, ADDR_MOD_CTRL0 + 8'h08, ADDR_RESULT0};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (raddr[i]) rdchk(raddr[i], 32'h0);
		$display("test reset values done");
		for (int i = 0; i < NMOD; i++) begin
			apb(1'b1, ADDR_MOD_CTRL0 + 8'(i) * ADDR_STRIDE, 32'hff);
			rdchk(ADDR_MOD_CTRL0 + 8'(i) * ADDR_STRIDE, {24'h0, MOD_CTRL_MASK});
			chk(32'(pins[4*i+:4]), 32'hf, "pins on");
			chk(32'({ren[i], sen[i]}), 32'h3, "osc on");
			apb(1'b1, ADDR_MOD_CTRL0 + 8'(i) * ADDR_STRIDE, 32'h0);
			chk(32'({pins, ren, sen}), 32'h0, "all off");
		end
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(err), 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		$display("test module control done");
		exp_cyc = (256 - 32'hfe) * 32 * 4;
		apb(1'b1, ADDR_MOD_CTRL0, 32'hb1);
		apb(1'b1, ADDR_PRELOAD, 32'hfe);
		apb(1'b1, ADDR_CTRL, 32'h24);
		wait_irq(1000);
		chk_rng(cyc, exp_cyc - 4, exp_cyc + 8, "slot time");
		chk(32'({ren, sen}), 32'h0, "osc stop");
		rdchk(ADDR_CTRL, 32'h64);
		rdchk(ADDR_REF_COUNT, 32'h0);
		apb(1'b0, ADDR_RESULT0, 32'h0);
		chk_rng(int'(rd), exp_cyc / 8 - 2, exp_cyc / 8 + 2, "sense count");
		apb(1'b1, ADDR_IRQ, 32'h0);
		chk(32'(irq), 32'h0, "irq clear");
		apb(1'b1, ADDR_CTRL, 32'h0);
		rdchk(ADDR_CTRL, 32'h0);
		$display("test shared slot done");
		// Module 1 ends early on pclk/4; interrupt waits for 0 and 2 on ref ticks
		exp_cyc = (256 - 32'hfe) * 32 * 8 - 204;
		apb(1'b1, ADDR_MOD_CTRL0, 32'h31);
		apb(1'b1, ADDR_MOD_CTRL0 + 8'h04, 32'hb2);
		apb(1'b1, ADDR_MOD_CTRL0 + 8'h08, 32'h34);
		apb(1'b1, ADDR_CTRL, 32'h23);
		repeat (200) @(posedge pclk);
		apb(1'b0, ADDR_REF_COUNT, 32'h0);
		chk_rng(int'(rd), 24, 26, "ref count pclk/8");
		wait_irq(1000);
		chk_rng(cyc, exp_cyc - 8, exp_cyc + 4, "own slot time");
		chk(32'({ren, sen}), 32'h0, "osc stop own");
		rdchk(ADDR_CTRL, 32'h63);
		apb(1'b0, ADDR_RESULT0, 32'h0);
		chk_rng(int'(rd), 62, 66, "sense count 0");
		apb(1'b0, ADDR_RESULT0 + 8'h04, 32'h0);
		chk_rng(int'(rd), 30, 34, "sense count 1");
		apb(1'b1, ADDR_IRQ, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h0);
		$display("test own slot done");
		for (int i = 0; i < NMOD; i++) apb(1'b1, ADDR_MOD_CTRL0 + 8'(i) * ADDR_STRIDE, 32'hb0);
		apb(1'b1, ADDR_CTRL, 32'h20);
		// Enables come back one edge after the start write lands
		@(posedge pclk);
		chk(32'({ren, sen}), 32'h3f, "restart osc");
		// No keys: the run never ends, so the pclk-rate reference counter wraps
		repeat (66000) @(posedge pclk);
		chk(32'(irq), 32'h0, "no keys no irq");
		rdchk(ADDR_CTRL, 32'h28);
		apb(1'b1, ADDR_CTRL, 32'h20);
		rdchk(ADDR_CTRL, 32'h20);
		$display("test no enabled keys done");
		stop_test();
	end
endmodule // tksc_top_tb
